//--- design/mssi_pkg.sv
package mssi_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int POS_W = 10;
	localparam int VEL_W = 24;
	localparam int RES_W = 4;
	localparam int PERIOD_W = 29;
	localparam int INTERVAL_W = 20;
	localparam int ADR_W = 8;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_VELOCITY = 8'h04;
	localparam logic [7:0] ADDR_COUNTER = 8'h08;
	localparam logic [7:0] ADDR_INTERVAL = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CFG_INDEX_STEP_BIT = 0;
	localparam int CFG_INTERP_BIT = 1;
	localparam int CFG_RES_LSB = 4;
	localparam int STAT_STANDSTILL_BIT = 0;
	localparam int STAT_STANDBY_BIT = 1;
	localparam logic [7:0] CONFIG_RESET = 8'h02;
	localparam logic [23:0] VELOCITY_RESET = 24'h000000;
	localparam logic [9:0] POS_RESET = 10'h000;
	localparam logic [3:0] RES_FULL = 4'h8;

	// Longest microstep spacing before standstill
	localparam logic [28:0] STANDSTILL_LIMIT = 29'h0010_0000;
	localparam logic [28:0] PERIOD_MAX = 29'h1fff_ffff;
	localparam logic [19:0] INTERVAL_MAX = 20'hfffff;

	typedef enum logic [0:0] {
		MSSI_IDLE = 1'b0,
		MSSI_RUN = 1'b1
	} mssi_state_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [9:0] step_width(input logic [3:0] res);
		step_width = 10'h001 << res;
	endfunction : step_width

	// Nearest valid position of a resolution: cell base plus half width
	function automatic logic [9:0] snap_pos(input logic [9:0] pos, input logic [3:0] res);
		logic [9:0] w;
		w = 10'h001 << res;
		snap_pos = (pos & ~(w - 10'h001)) | (w >> 1);
	endfunction : snap_pos

	function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		wb_merge = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				wb_merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction : wb_merge

endpackage : mssi_pkg

//--- design/mssi_velgen.sv
`timescale 1ns/1ns
`default_nettype none

module mssi_velgen (
	input wire logic clk,
	input wire logic reset,
	input wire logic [23:0] velocity,
	output logic pulse,
	output logic dir
);

	logic [23:0] acc_reg;
	logic pulse_reg;
	logic dir_reg;
	logic [23:0] mag;
	logic [24:0] sum;

	// Magnitude of two's complement setpoint, applied at once
	assign mag = velocity[23] ? (24'h000000 - velocity) : velocity;
	assign sum = {1'b0, acc_reg} + {1'b0, mag};

	// Carry out gives rate = |v| * fclk / 2^24
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_reg <= 24'h000000;
			pulse_reg <= 1'b0;
			dir_reg <= 1'b0;
		end else begin
			acc_reg <= sum[23:0];
			pulse_reg <= sum[24];
			dir_reg <= velocity[23];
		end
	end

	assign pulse = pulse_reg;
	assign dir = dir_reg;

	property p_gen_needs_velocity;
		@(posedge clk) disable iff (reset)
		pulse_reg |-> $past(velocity) != 24'h000000;
	endproperty
	a_gen_needs_velocity: assert property (p_gen_needs_velocity)
		else $error("step generator pulsed with zero setpoint");

endmodule : mssi_velgen

`default_nettype wire

//--- design/mssi_sequencer.sv
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module mssi_sequencer (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic STEP,
	input wire logic DIR,
	input wire logic POWERDOWN_SELECT,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic INDEX,
	output logic STANDSTILL,
	output logic STANDBY
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic step_s1_reg, step_s2_reg, step_s3_reg;
	logic dir_s1_reg, dir_s2_reg;
	logic pdn_s1_reg, pdn_s2_reg;
	logic [7:0] config_reg;
	logic [23:0] velocity_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [9:0] pos_reg, pos_next;
	logic [9:0] tgt_reg, tgt_next;
	logic [9:0] rem_reg, rem_next;
	logic [19:0] tick_reg, tick_next;
	logic [19:0] spacing_reg;
	logic [19:0] interval_reg;
	logic [28:0] period_reg;
	logic [3:0] res_prev_reg;
	logic standstill_reg, standstill_next;
	logic index_reg, index_next;
	logic run_dir_reg, run_dir_next;
	mssi_pkg::mssi_state_t state_reg, state_next;

	wire logic vel_pulse;
	wire logic vel_dir;
	wire logic vel_active;
	wire logic ext_edge;
	wire logic cmd_edge;
	wire logic cmd_dir;
	wire logic cfg_index_step;
	wire logic cfg_interp;
	wire logic [3:0] cfg_res;
	wire logic [3:0] eff_res;
	wire logic res_coarser;
	wire logic [9:0] width;
	wire logic [9:0] base_tgt;
	wire logic [9:0] tgt_step;
	wire logic [28:0] interval_now;
	wire logic too_long;
	wire logic [19:0] interval_sat;
	wire logic interp_ok;
	wire logic tick_done;
	wire logic wb_req;
	wire logic wb_write;
	wire logic [31:0] cfg_merged;
	wire logic [31:0] vel_merged;
	logic [31:0] rd_data;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			step_s1_reg <= 1'b0;
			step_s2_reg <= 1'b0;
			step_s3_reg <= 1'b0;
			dir_s1_reg <= 1'b0;
			dir_s2_reg <= 1'b0;
			pdn_s1_reg <= 1'b0;
			pdn_s2_reg <= 1'b0;
		end else begin
			step_s1_reg <= STEP;
			step_s2_reg <= step_s1_reg;
			step_s3_reg <= step_s2_reg;
			dir_s1_reg <= DIR;
			dir_s2_reg <= dir_s1_reg;
			pdn_s1_reg <= POWERDOWN_SELECT;
			pdn_s2_reg <= pdn_s1_reg;
		end
	end

	// ----------------------------------------
	// Internal step generator
	// ----------------------------------------
	mssi_velgen u_velgen (
		.clk(REF_CLK),
		.reset(RESET),
		.velocity(velocity_reg),
		.pulse(vel_pulse),
		.dir(vel_dir)
	);

	// ----------------------------------------
	// Step command decode
	// ----------------------------------------
	assign ext_edge = step_s2_reg & ~step_s3_reg;
	assign vel_active = velocity_reg != 24'h000000;
	assign cmd_edge = vel_active ? vel_pulse : ext_edge;
	assign cmd_dir = vel_active ? vel_dir : dir_s2_reg;
	assign cfg_index_step = config_reg[mssi_pkg::CFG_INDEX_STEP_BIT];
	assign cfg_interp = config_reg[mssi_pkg::CFG_INTERP_BIT];
	assign cfg_res = (config_reg[mssi_pkg::CFG_RES_LSB +: 4] > mssi_pkg::RES_FULL) ?
		mssi_pkg::RES_FULL : config_reg[mssi_pkg::CFG_RES_LSB +: 4];
	assign eff_res = vel_active ? 4'h0 : cfg_res;
	assign res_coarser = eff_res > res_prev_reg;
	assign width = mssi_pkg::step_width(eff_res);
	assign base_tgt = res_coarser ? mssi_pkg::snap_pos(tgt_reg, eff_res) : tgt_reg;
	assign tgt_step = cmd_dir ? (base_tgt - width) : (base_tgt + width);

	// ----------------------------------------
	// Interval measurement and standstill
	// ----------------------------------------
	assign interval_now = period_reg >> eff_res;
	assign too_long = interval_now > mssi_pkg::STANDSTILL_LIMIT;
	assign interval_sat = (interval_now > {9'h000, mssi_pkg::INTERVAL_MAX}) ?
		mssi_pkg::INTERVAL_MAX : interval_now[19:0];
	assign interp_ok = cfg_interp & (eff_res != 4'h0) & ~standstill_reg
		& (interval_sat != 20'h00000);
	assign tick_done = tick_reg >= (spacing_reg - 20'h00001);
	assign standstill_next = cmd_edge ? 1'b0 : (too_long | standstill_reg);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		pos_next = pos_reg;
		tgt_next = tgt_reg;
		rem_next = rem_reg;
		tick_next = tick_reg;
		run_dir_next = run_dir_reg;
		state_next = state_reg;
		if (res_coarser) begin
			pos_next = mssi_pkg::snap_pos(pos_reg, eff_res);
			tgt_next = base_tgt;
			state_next = mssi_pkg::MSSI_IDLE;
		end
		if (cmd_edge) begin
			if (interp_ok) begin
				pos_next = base_tgt;
				tgt_next = tgt_step;
				rem_next = width;
				tick_next = 20'h00000;
				run_dir_next = cmd_dir;
				state_next = mssi_pkg::MSSI_RUN;
			end else begin
				pos_next = tgt_step;
				tgt_next = tgt_step;
				state_next = mssi_pkg::MSSI_IDLE;
			end
		end else if (!res_coarser) begin
			case (state_reg)
				mssi_pkg::MSSI_RUN: begin
					if (tick_done) begin
						pos_next = run_dir_reg ? (pos_reg - 10'h001) : (pos_reg + 10'h001);
						tick_next = 20'h00000;
						rem_next = rem_reg - 10'h001;
						if (rem_reg == 10'h001) begin
							state_next = mssi_pkg::MSSI_IDLE;
						end
					end else begin
						tick_next = tick_reg + 20'h00001;
					end
				end
				default: begin
					state_next = mssi_pkg::MSSI_IDLE;
				end
			endcase
		end
	end

	assign index_next = cfg_index_step ? (index_reg ^ (pos_next != pos_reg))
		: (pos_next == 10'h000);

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pos_reg <= mssi_pkg::POS_RESET;
			tgt_reg <= mssi_pkg::POS_RESET;
			rem_reg <= 10'h000;
			tick_reg <= 20'h00000;
			run_dir_reg <= 1'b0;
			state_reg <= mssi_pkg::MSSI_IDLE;
			index_reg <= 1'b1;
			res_prev_reg <= 4'h0;
		end else begin
			pos_reg <= pos_next;
			tgt_reg <= tgt_next;
			rem_reg <= rem_next;
			tick_reg <= tick_next;
			run_dir_reg <= run_dir_next;
			state_reg <= state_next;
			index_reg <= index_next;
			res_prev_reg <= eff_res;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			period_reg <= 29'h0000_0000;
			spacing_reg <= 20'h00000;
			interval_reg <= mssi_pkg::INTERVAL_MAX;
			standstill_reg <= 1'b1;
		end else begin
			period_reg <= cmd_edge ? 29'h0000_0001 :
				((period_reg == mssi_pkg::PERIOD_MAX) ? period_reg : period_reg + 29'h0000_0001);
			spacing_reg <= cmd_edge ? interval_sat : spacing_reg;
			interval_reg <= cmd_edge ? interval_sat : (too_long ? mssi_pkg::INTERVAL_MAX : interval_reg);
			standstill_reg <= standstill_next;
		end
	end

	assign INDEX = index_reg;
	assign STANDSTILL = standstill_reg;
	assign STANDBY = standstill_reg & pdn_s2_reg;

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	assign wb_req = WB_CYC_I & WB_STB_I;
	assign wb_write = wb_req & WB_WE_I & ack_reg;
	assign cfg_merged = mssi_pkg::wb_merge({24'h000000, config_reg}, WB_DAT_I, WB_SEL_I);
	assign vel_merged = mssi_pkg::wb_merge({8'h00, velocity_reg}, WB_DAT_I, WB_SEL_I);

	always_comb begin
		case (WB_ADR_I)
			mssi_pkg::ADDR_CONFIG: rd_data = {24'h000000, config_reg};
			mssi_pkg::ADDR_VELOCITY: rd_data = {8'h00, velocity_reg};
			mssi_pkg::ADDR_COUNTER: rd_data = {22'h000000, pos_reg};
			mssi_pkg::ADDR_INTERVAL: rd_data = {12'h000, interval_reg};
			mssi_pkg::ADDR_STATUS: rd_data = {30'h00000000, STANDBY, standstill_reg};
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			config_reg <= mssi_pkg::CONFIG_RESET;
			velocity_reg <= mssi_pkg::VELOCITY_RESET;
		end else begin
			ack_reg <= wb_req & ~ack_reg;
			dat_reg <= (wb_req & ~ack_reg) ? rd_data : dat_reg;
			if (wb_write && WB_ADR_I == mssi_pkg::ADDR_CONFIG) begin
				config_reg <= cfg_merged[7:0];
			end
			if (wb_write && WB_ADR_I == mssi_pkg::ADDR_VELOCITY) begin
				velocity_reg <= vel_merged[23:0];
			end
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = dat_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_step_clears_standstill;
		@(posedge REF_CLK) disable iff (RESET)
		cmd_edge |=> !standstill_reg;
	endproperty
	a_step_clears_standstill: assert property (p_step_clears_standstill)
		else $error("standstill flag survived a step edge");

	property p_standstill_cause;
		@(posedge REF_CLK) disable iff (RESET)
		$rose(standstill_reg) |-> $past(too_long) && !$past(cmd_edge);
	endproperty
	a_standstill_cause: assert property (p_standstill_cause)
		else $error("standstill raised without long interval");

	property p_standby_follows;
		@(posedge REF_CLK) disable iff (RESET)
		($rose(standstill_reg) && pdn_s2_reg) |-> STANDBY;
	endproperty
	a_standby_follows: assert property (p_standby_follows)
		else $error("standby not started at standstill");

	property p_index_zero;
		@(posedge REF_CLK) disable iff (RESET)
		(!cfg_index_step && $past(!cfg_index_step)) |-> (INDEX == (pos_reg == 10'h000));
	endproperty
	a_index_zero: assert property (p_index_zero)
		else $error("index not tied to zero position");

	property p_index_toggle;
		@(posedge REF_CLK) disable iff (RESET)
		(cfg_index_step && $past(cfg_index_step) && pos_reg != $past(pos_reg))
			|-> INDEX != $past(INDEX);
	endproperty
	a_index_toggle: assert property (p_index_toggle)
		else $error("index did not toggle on executed step");

	property p_fullstep_grid;
		@(posedge REF_CLK) disable iff (RESET)
		(eff_res == mssi_pkg::RES_FULL && $past(eff_res) == mssi_pkg::RES_FULL
			&& state_reg == mssi_pkg::MSSI_IDLE) |-> pos_reg[7:0] == 8'h80;
	endproperty
	a_fullstep_grid: assert property (p_fullstep_grid)
		else $error("fullstep position off grid");

	property p_step_width;
		@(posedge REF_CLK) disable iff (RESET)
		(cmd_edge && !interp_ok && !res_coarser)
			|=> pos_reg == ($past(cmd_dir) ? $past(tgt_reg) - $past(width)
				: $past(tgt_reg) + $past(width));
	endproperty
	a_step_width: assert property (p_step_width)
		else $error("step moved by wrong width");

	property p_wrap_up;
		@(posedge REF_CLK) disable iff (RESET)
		(cmd_edge && eff_res == 4'h0 && !cmd_dir && !res_coarser && tgt_reg == 10'h3ff)
			|=> pos_reg == 10'h000;
	endproperty
	a_wrap_up: assert property (p_wrap_up)
		else $error("counter did not wrap from 1023 to 0");

	property p_run_ends;
		@(posedge REF_CLK) disable iff (RESET)
		(state_reg == mssi_pkg::MSSI_RUN && rem_reg == 10'h001 && tick_done
			&& !cmd_edge && !res_coarser)
			|=> state_reg == mssi_pkg::MSSI_IDLE;
	endproperty
	a_run_ends: assert property (p_run_ends)
		else $error("interpolation overran its microsteps");

endmodule : mssi_sequencer

`default_nettype wire

//--- test/mssi_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

module mssi_ctrl_model (
	input wire logic clk,
	output logic step,
	output logic dir
);
	initial begin
		step = 1'b0;
		dir = 1'b0;
	end

	// ----------------------------------------
	// One step pulse, direction settled around it
	// ----------------------------------------
	task automatic pulse(input logic d);
		dir <= d;
		repeat (2) @(posedge clk);
		step <= 1'b1;
		repeat (3) @(posedge clk);
		step <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse
endmodule : mssi_ctrl_model

`default_nettype wire

//--- test/microstep_sequencer_interpolator_bench.sv
`timescale 1ns/1ns
`default_nettype none

module microstep_sequencer_interpolator_bench;
	localparam logic [7:0] A_CFG = mssi_pkg::ADDR_CONFIG;
	localparam logic [7:0] A_VEL = mssi_pkg::ADDR_VELOCITY;
	localparam logic [7:0] A_CNT = mssi_pkg::ADDR_COUNTER;
	logic clk, rst, pds, cyc, stb, we, i0, seen;
	logic [7:0] adr;
	logic [3:0] sel, bsel;
	logic [31:0] dat, q;
	logic [9:0] c0, d, p;
	wire logic [31:0] rdat;
	wire logic ack, idx, stst, stby, step, dir;
	int num_errors, n_tests;
	logic [7:0] op [11] = '{8'h60, 8'hff, 8'h70, 8'hff, 8'h80, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hfe};
	logic [9:0] ex [11] = '{10'd32, 10'd96, 10'd64, 10'd192, 10'd128, 10'd384, 10'd640,
		10'd896, 10'd128, 10'd384, 10'd128};

	mssi_ctrl_model m_u (.clk(clk), .step(step), .dir(dir));

	mssi_sequencer dut_u (.REF_CLK(clk), .RESET(rst), .STEP(step), .DIR(dir),
		.POWERDOWN_SELECT(pds), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.INDEX(idx), .STANDSTILL(stst), .STANDBY(stby));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// Bus access and comparison
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= bsel;
		dat <= v;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		chk("wb_ack", 32'h1, {31'h0, ack});
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rc

	task automatic end_sim;
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		num_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		pds = 1'b0;
		bsel = 4'hf;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("index", 32'h1, {31'h0, idx});
		chk("standstill", 32'h1, {31'h0, stst});
		chk("standby", 32'h0, {31'h0, stby});
		rc("config", A_CFG, 32'h2);
		rc("velocity", A_VEL, 32'h0);
		rc("counter", A_CNT, 32'h0);
		rc("unmapped", 8'h20, 32'h0);
		pds <= 1'b1;
		repeat (3) @(posedge clk);
		chk("standby", 32'h1, {31'h0, stby});
		rc("status", mssi_pkg::ADDR_STATUS, 32'h3);
		wb(1'b1, A_CNT, 32'h5);
		rc("counter_ro", A_CNT, 32'h0);
		bsel = 4'he;
		wb(1'b1, A_CFG, 32'hff);
		bsel = 4'hf;
		rc("config_sel", A_CFG, 32'h2);
		wb(1'b1, A_CFG, 32'h0);
		m_u.pulse(1'b0);
		rc("step_up", A_CNT, 32'h1);
		chk("standstill", 32'h0, {31'h0, stst});
		chk("standby", 32'h0, {31'h0, stby});
		chk("index", 32'h0, {31'h0, idx});
		m_u.pulse(1'b1);
		m_u.pulse(1'b1);
		rc("wrap_down", A_CNT, 32'h3ff);
		m_u.pulse(1'b0);
		rc("wrap_up", A_CNT, 32'h0);
		chk("index", 32'h1, {31'h0, idx});
		for (int i = 0; i < 11; i++) begin
			if (op[i] == 8'hff || op[i] == 8'hfe) begin
				m_u.pulse(op[i][0] ? 1'b0 : 1'b1);
			end else begin
				wb(1'b1, A_CFG, {24'h0, op[i]});
			end
			rc("res_pos", A_CNT, {22'h0, ex[i]});
		end
		wb(1'b1, A_CFG, 32'h1);
		i0 = idx;
		m_u.pulse(1'b0);
		chk("index_step", {31'h0, ~i0}, {31'h0, idx});
		m_u.pulse(1'b0);
		chk("index_step", {31'h0, i0}, {31'h0, idx});
		wb(1'b1, A_CFG, 32'h0);
		wb(1'b1, A_VEL, 32'h080000);
		wb(1'b1, A_VEL, 32'h100000);
		wb(1'b0, A_CNT, 32'h0);
		c0 = q[9:0];
		repeat (320) @(posedge clk);
		wb(1'b0, A_CNT, 32'h0);
		d = q[9:0] - c0;
		chk("vel_up", 32'h1, {31'h0, d >= 10'd19 && d <= 10'd22});
		rc("interval", mssi_pkg::ADDR_INTERVAL, 32'd16);
		wb(1'b1, A_VEL, 32'hf00000);
		wb(1'b0, A_CNT, 32'h0);
		c0 = q[9:0];
		repeat (320) @(posedge clk);
		wb(1'b0, A_CNT, 32'h0);
		d = c0 - q[9:0];
		chk("vel_down", 32'h1, {31'h0, d >= 10'd19 && d <= 10'd22});
		wb(1'b1, A_VEL, 32'h0);
		repeat (20) @(posedge clk);
		wb(1'b0, A_CNT, 32'h0);
		c0 = q[9:0];
		repeat (50) @(posedge clk);
		rc("vel_stop", A_CNT, {22'h0, c0});
		wb(1'b1, A_CFG, 32'h12);
		wb(1'b0, A_CNT, 32'h0);
		p = q[9:0];
		chk("snap_half", 32'h1, {31'h0, p[0]});
		repeat (3) begin
			m_u.pulse(1'b0);
			repeat (292) @(posedge clk);
		end
		m_u.pulse(1'b0);
		seen = 1'b0;
		repeat (60) begin
			wb(1'b0, A_CNT, 32'h0);
			if (q[0] === 1'b0) begin
				seen = 1'b1;
			end
		end
		repeat (200) @(posedge clk);
		chk("interp_mid", 32'h1, {31'h0, seen});
		rc("interp_end", A_CNT, {22'h0, p + 10'd8});
		end_sim();
	end
endmodule : microstep_sequencer_interpolator_bench

`default_nettype wire
